// ---- sss_chan_if.sv ----
`timescale 1ns/1ps

interface sss_chan_if;
  logic active;
  logic seenLow;

  modport mon (
    output active,
    output seenLow
  );

  modport seq (
    input active,
    input seenLow
  );
endinterface : sss_chan_if

// ---- sss_chan_mon.sv ----
`timescale 1ns/1ps

module sss_chan_mon (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic chIn,
  sss_chan_if.mon ch
);

  logic seenLow;

  // ============================================================
  // inactive at any time since power-up counts as a deactivation
  assign ch.active = chIn;
  assign ch.seenLow = seenLow;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      seenLow <= 1'b0;
    else if (!chIn)
      seenLow <= 1'b1;
  end

  // ============================================================
  // checks
  chk_seen_low_set: assert property (
    @(posedge clk) disable iff (!arst_n)
    !chIn |=> seenLow)
    else $error("deactivation not recorded");

  chk_seen_low_sticky: assert property (
    @(posedge clk) disable iff (!arst_n)
    seenLow |=> seenLow)
    else $error("deactivation record lost");

endmodule : sss_chan_mon

// ---- sss_far_model.sv ----
`timescale 1ns/1ps

// ============================================================
// sensor pair and start source, driven on the falling edge
module sss_far_model #(
  parameter int RECOVERY = 20,
  parameter int POWERON = 30,
  parameter int PULSE = 8
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic reqA,
  input wire logic reqB,
  input wire logic reqStart,
  output logic chA,
  output logic chB,
  output logic startOut
);
  int recA;
  int recB;
  int poCnt;
  int holdCnt;

  always_ff @(negedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      chA <= reqA;
      chB <= reqB;
      recA <= 0;
      recB <= 0;
      poCnt <= 0;
      holdCnt <= 0;
      startOut <= 1'b0;
    end
    else
    begin
      // a sensor never comes back before its recovery time
      if (chA && !reqA) recA <= RECOVERY;
      else if (recA > 0) recA <= recA - 1;
      chA <= reqA && (chA || recA == 0);
      if (chB && !reqB) recB <= RECOVERY;
      else if (recB > 0) recB <= recB - 1;
      chB <= reqB && (chB || recB == 0);
      if (poCnt < POWERON) poCnt <= poCnt + 1;
      holdCnt <= startOut ? holdCnt + 1 : 0;
      if (!startOut) startOut <= reqStart && poCnt >= POWERON;
      else startOut <= reqStart || holdCnt < PULSE;
    end
  end
endmodule : sss_far_model

// ---- sss_pkg.sv ----
package sss_pkg;

  // ============================================================
  // sequencer states
  typedef enum logic [1:0] {
    ST_SAFE = 2'b00,
    ST_PULSE = 2'b01,
    ST_RUN = 2'b10
  } sss_state_t;

  // ============================================================
  // decoded start function
  typedef struct packed {
    logic monitored;
    logic startupTest;
    logic dynamization;
  } sss_cfg_t;

endpackage : sss_pkg

// ---- sss_regs.svh ----
`ifndef SSS_REGS_SVH
`define SSS_REGS_SVH

// ============================================================
// clock
`define SSS_CLK_HZ 40000000
`define SSS_CYC_PER_MS (`SSS_CLK_HZ / 1000)

// ============================================================
// timing figures in ms
`define SSS_SYNC_WINDOW_MS 500
`define SSS_ACT_DELAY_MS 100
`define SSS_RESPONSE_MS 20
`define SSS_RECOVERY_MS 200
`define SSS_START_PULSE_MS 80
`define SSS_POWERON_WAIT_MS 2500

// ============================================================
// derived cycle counts
`define SSS_SYNC_CYCLES (`SSS_SYNC_WINDOW_MS * `SSS_CYC_PER_MS)
`define SSS_ACT_DELAY_CYCLES (`SSS_ACT_DELAY_MS * `SSS_CYC_PER_MS)
`define SSS_RESPONSE_CYCLES (`SSS_RESPONSE_MS * `SSS_CYC_PER_MS)

// ============================================================
// start function selector
`define SSS_SEL_W 4
`define SSS_SEL_MIN 4'h1
`define SSS_SEL_MAX 4'h8
`define SSS_SEL_BIT_TEST 0
`define SSS_SEL_BIT_MONITORED 1
`define SSS_SEL_BIT_NODYN 2

`endif

// ---- sss_sequencer.sv ----
`timescale 1ns/1ps
`include "sss_regs.svh"

module sss_sequencer #(
  parameter int SYNC_CYCLES = `SSS_SYNC_CYCLES,
  parameter int NUM_OUT = 2
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic channel_a_input,
  input wire logic channel_b_input,
  input wire logic startIn,
  input wire logic syncEnable,
  input wire logic [`SSS_SEL_W-1:0] selPos,
  output logic [NUM_OUT-1:0] safeOut,
  output logic running,
  output logic cfgError,
  output logic dynEnable,
  output logic syncFault,
  output logic testPending
);

  if (NUM_OUT < 1)
  begin : g_bad_out
    $error("sss_sequencer: NUM_OUT must be at least 1");
  end
  if (SYNC_CYCLES < 1)
  begin : g_bad_sync
    $error("sss_sequencer: SYNC_CYCLES must be at least 1");
  end

  // ============================================================
  // channel monitors, one per channel input
  sss_chan_if chA ();
  sss_chan_if chB ();

  sss_chan_mon u_mon_a (
    .clk(clk),
    .arst_n(arst_n),
    .chIn(channel_a_input),
    .ch(chA)
  );

  sss_chan_mon u_mon_b (
    .clk(clk),
    .arst_n(arst_n),
    .chIn(channel_b_input),
    .ch(chB)
  );

  // ============================================================
  // selector capture and decode
  logic cfgCaptured;
  logic [`SSS_SEL_W-1:0] selLatched;
  logic cfgErr;
  sss_pkg::sss_cfg_t cfg;

  wire [`SSS_SEL_W-1:0] posIdx = selLatched - `SSS_SEL_MIN;
  wire selInRange = (selLatched >= `SSS_SEL_MIN) &&
    (selLatched <= `SSS_SEL_MAX);
  wire selMoved = cfgCaptured && (selPos != selLatched);
  wire next_cfgErr = cfgErr || selMoved ||
    (cfgCaptured && !selInRange);

  assign cfg.monitored = posIdx[`SSS_SEL_BIT_MONITORED];
  assign cfg.startupTest = posIdx[`SSS_SEL_BIT_TEST];
  assign cfg.dynamization = !posIdx[`SSS_SEL_BIT_NODYN];

  // straps are caught on the first edge after release, never by reset
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      cfgCaptured <= 1'b0;
    else
      cfgCaptured <= 1'b1;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      selLatched <= '0;
    else if (!cfgCaptured)
      selLatched <= selPos;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      cfgErr <= 1'b0;
    else
      cfgErr <= next_cfgErr;
  end

  // ============================================================
  // channel synchronization
  logic pairOk;
  logic syncFail;
  logic pairArmed;
  logic windowExpired;

  wire bothHigh = chA.active && chB.active;
  wire bothLow = !chA.active && !chB.active;
  wire oneHigh = chA.active ^ chB.active;
  wire windowRun = syncEnable && oneHigh && pairArmed;

  sss_window_timer #(
    .COUNT(SYNC_CYCLES)
  ) u_sync_timer (
    .clk(clk),
    .arst_n(arst_n),
    .run(windowRun),
    .expired(windowExpired)
  );

  // a pair only forms from the idle state, so a late channel cannot
  // rejoin a partner that stayed active
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      pairArmed <= 1'b0;
    else if (bothLow)
      pairArmed <= 1'b1;
    else if (pairOk || syncFail || (windowExpired && oneHigh))
      pairArmed <= 1'b0;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      pairOk <= 1'b0;
    else if (!bothHigh)
      pairOk <= 1'b0;
    else if (pairArmed && !syncFail)
      pairOk <= 1'b1;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      syncFail <= 1'b0;
    else if (windowExpired && oneHigh)
      syncFail <= 1'b1;
    else if (bothLow)
      syncFail <= 1'b0;
  end

  // ============================================================
  // startup test
  logic testDone;

  wire testPass = chA.seenLow && chB.seenLow && bothHigh;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      testDone <= 1'b0;
    else if (testPass)
      testDone <= 1'b1;
  end

  // ============================================================
  // start sequencing
  sss_pkg::sss_state_t state;
  sss_pkg::sss_state_t next_state;
  logic startPrev;

  wire startRise = startIn && !startPrev;
  wire startFall = !startIn && startPrev;
  wire inputsOk = bothHigh && pairOk && !syncFail;
  wire cfgOk = cfgCaptured && !next_cfgErr;
  wire testOk = testDone || !cfg.startupTest;
  wire goCond = cfgOk && inputsOk && testOk;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      startPrev <= 1'b0;
    else
      startPrev <= startIn;
  end

  // one machine serves power-on and every later restart
  always_comb
  begin
    next_state = state;
    case (state)
      sss_pkg::ST_SAFE:
      begin
        if (cfgOk && cfg.monitored && startRise)
          next_state = sss_pkg::ST_PULSE;
        else if (goCond && !cfg.monitored && startIn)
          next_state = sss_pkg::ST_RUN;
      end
      sss_pkg::ST_PULSE:
      begin
        // pulse length is the source's duty; short pulses are accepted
        if (!cfgOk)
          next_state = sss_pkg::ST_SAFE;
        else if (startFall && goCond)
          next_state = sss_pkg::ST_RUN;
        else if (startFall)
          next_state = sss_pkg::ST_SAFE;
      end
      sss_pkg::ST_RUN:
      begin
        if (!bothHigh || syncFail || !cfgOk)
          next_state = sss_pkg::ST_SAFE;
      end
      default:
        next_state = sss_pkg::ST_SAFE;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      state <= sss_pkg::ST_SAFE;
    else
      state <= next_state;
  end

  // ============================================================
  // outputs, all registered
  wire next_run = (next_state == sss_pkg::ST_RUN);

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      safeOut <= '0;
      running <= 1'b0;
    end
    else
    begin
      safeOut <= {NUM_OUT{next_run}};
      running <= next_run;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cfgError <= 1'b0;
      dynEnable <= 1'b0;
      syncFault <= 1'b0;
      testPending <= 1'b0;
    end
    else
    begin
      cfgError <= next_cfgErr;
      dynEnable <= cfgCaptured && selInRange && cfg.dynamization;
      syncFault <= syncFail;
      testPending <= cfgCaptured && cfg.startupTest && !testDone;
    end
  end

  // ============================================================
  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  chk_drop_fast: assert property (
    !bothHigh |-> ##[1:2] !safeOut[0])
    else $error("outputs not dropped after input loss");

  chk_auto_energize: assert property (
    (state == sss_pkg::ST_SAFE && !cfg.monitored && goCond && startIn)
    |=> safeOut[0])
    else $error("automatic start did not energize");

  chk_manual_start: assert property (
    ($rose(safeOut[0]) && !cfg.monitored) |-> $past(startIn))
    else $error("energized without start input");

  chk_monitored_edge: assert property (
    ($rose(safeOut[0]) && cfg.monitored)
    |-> ($past(startIn, 2) && !$past(startIn)))
    else $error("monitored start without falling edge");

  chk_startup_test: assert property (
    (cfg.startupTest && !testDone) |=> !safeOut[0])
    else $error("energized before startup test");

  chk_sync_hold: assert property (
    syncFail |=> (!safeOut[0] && (syncFail || $past(bothLow))))
    else $error("sync failure released early");

  chk_cfg_change: assert property (
    (selMoved && cfgCaptured) |=> (cfgError && !safeOut[0]))
    else $error("selector change not flagged");

  chk_cfg_frozen: assert property (
    cfgCaptured |=> $stable(selLatched))
    else $error("selector resampled while powered");

  chk_dyn_decode: assert property (
    cfgCaptured |=> (dynEnable == (selLatched >= 4'h1 && selLatched <= 4'h4)))
    else $error("dynamization decode wrong");

  chk_outputs_agree: assert property (
    safeOut == {NUM_OUT{safeOut[0]}})
    else $error("safety outputs disagree");

  cov_auto_run: cover property (
    !cfg.monitored && startIn ##1 $rose(running));
  cov_monitored_run: cover property (
    cfg.monitored && state == sss_pkg::ST_PULSE ##1 $rose(running));
  cov_sync_fail: cover property ($rose(syncFault));
  cov_cfg_error: cover property ($rose(cfgError));

endmodule : sss_sequencer

// ---- sss_sequencer_tb_top.sv ----
`timescale 1ns/1ps
`include "sss_regs.svh"

`define CHK(nm, ex, got) \
  begin \
    compares++; \
    if ((got) !== (ex)) \
    begin \
      n_mismatch++; \
      $display("[ERR] %s exp %0h got %0h", nm, ex, got); \
    end \
  end

module sss_sequencer_tb_top;
  logic clk;
  logic arst_n;
  logic reqA, reqB, reqStart, syncEnable;
  logic [`SSS_SEL_W-1:0] selPos;
  logic chA, chB, startIn;
  logic [1:0] safeOut;
  logic running, cfgError, dynEnable, syncFault, testPending;
  int n_mismatch, compares, cyc;

  sss_far_model sss_far_model_inst (.clk(clk), .arst_n(arst_n),
    .reqA(reqA), .reqB(reqB), .reqStart(reqStart),
    .chA(chA), .chB(chB), .startOut(startIn));

  // short window keeps the fault case quick
  sss_sequencer #(.SYNC_CYCLES(50), .NUM_OUT(2)) sss_sequencer_inst (
    .clk(clk), .arst_n(arst_n), .channel_a_input(chA),
    .channel_b_input(chB), .startIn(startIn), .syncEnable(syncEnable),
    .selPos(selPos), .safeOut(safeOut), .running(running),
    .cfgError(cfgError), .dynEnable(dynEnable), .syncFault(syncFault),
    .testPending(testPending));

  // ============================================================
  // helpers
  task automatic power_up(input logic [`SSS_SEL_W-1:0] pos,
    input logic a, input logic b, input logic s);
    arst_n <= 1'b0;
    selPos <= pos;
    reqA <= a;
    reqB <= b;
    reqStart <= s;
    repeat (5) @(negedge clk);
    arst_n <= 1'b1;
    repeat (3) @(negedge clk);
  endtask : power_up

  task automatic drive(input logic a, input logic b, input logic s);
    reqA <= a;
    reqB <= b;
    reqStart <= s;
    @(negedge clk);
  endtask : drive

  task automatic wait_out(input logic [1:0] ex, input int n);
    for (int i = 0; i < n && safeOut !== ex; i++) @(negedge clk);
  endtask : wait_out

  // ============================================================
  // scenarios
  task automatic t_manual;
    power_up(4'h5, 1'b0, 1'b0, 1'b0);
    drive(1'b1, 1'b1, 1'b0);
    repeat (40) @(negedge clk);
    `CHK("out no start", 2'h0, safeOut)
    drive(1'b1, 1'b1, 1'b1);
    wait_out(2'h3, 50);
    `CHK("out manual", 2'h3, safeOut)
    `CHK("running", 1'h1, running)
    `CHK("dyn off", 1'h0, dynEnable)
    drive(1'b0, 1'b1, 1'b1);
    wait_out(2'h0, 4);
    `CHK("out drop", 2'h0, safeOut)
    drive(1'b0, 1'b0, 1'b1);
    repeat (25) @(negedge clk);
    drive(1'b1, 1'b1, 1'b1);
    wait_out(2'h3, 40);
    `CHK("out auto", 2'h3, safeOut)
    $display("test manual done");
  endtask : t_manual

  task automatic t_monitored;
    power_up(4'h7, 1'b0, 1'b0, 1'b0);
    drive(1'b1, 1'b1, 1'b0);
    repeat (40) @(negedge clk);
    drive(1'b1, 1'b1, 1'b1);
    repeat (12) @(negedge clk);
    `CHK("out held", 2'h0, safeOut)
    drive(1'b1, 1'b1, 1'b0);
    wait_out(2'h3, 10);
    `CHK("out fall", 2'h3, safeOut)
    drive(1'b0, 1'b0, 1'b0);
    repeat (25) @(negedge clk);
    drive(1'b1, 1'b1, 1'b0);
    repeat (30) @(negedge clk);
    `CHK("out restart", 2'h0, safeOut)
    drive(1'b0, 1'b0, 1'b1);
    repeat (25) @(negedge clk);
    drive(1'b0, 1'b0, 1'b0);
    repeat (5) @(negedge clk);
    drive(1'b1, 1'b1, 1'b0);
    repeat (30) @(negedge clk);
    `CHK("out idle pulse", 2'h0, safeOut)
    $display("test monitored done");
  endtask : t_monitored

  task automatic t_startup;
    power_up(4'h6, 1'b1, 1'b1, 1'b1);
    `CHK("test pend", 1'h1, testPending)
    repeat (40) @(negedge clk);
    `CHK("out untested", 2'h0, safeOut)
    drive(1'b0, 1'b1, 1'b1);
    repeat (25) @(negedge clk);
    drive(1'b0, 1'b0, 1'b1);
    repeat (25) @(negedge clk);
    drive(1'b1, 1'b0, 1'b1);
    repeat (5) @(negedge clk);
    `CHK("out half", 2'h0, safeOut)
    drive(1'b1, 1'b1, 1'b1);
    wait_out(2'h3, 40);
    `CHK("out tested", 2'h3, safeOut)
    power_up(4'h2, 1'b0, 1'b0, 1'b1);
    drive(1'b1, 1'b1, 1'b1);
    wait_out(2'h3, 60);
    `CHK("out low start", 2'h3, safeOut)
    $display("test startup done");
  endtask : t_startup

  task automatic t_decode;
    for (int p = 1; p <= 8; p++)
    begin
      power_up(p[3:0], 1'b1, 1'b1, 1'b0);
      `CHK("dyn", p <= 4, dynEnable)
      `CHK("pend", p % 2 == 0, testPending)
      `CHK("cfg ok", 1'h0, cfgError)
    end
    power_up(4'h0, 1'b0, 1'b0, 1'b0);
    `CHK("cfg zero", 1'h1, cfgError)
    $display("test decode done");
  endtask : t_decode

  task automatic t_selchange;
    power_up(4'h5, 1'b0, 1'b0, 1'b1);
    drive(1'b1, 1'b1, 1'b1);
    wait_out(2'h3, 60);
    `CHK("out pre", 2'h3, safeOut)
    selPos <= 4'h1;
    repeat (3) @(negedge clk);
    `CHK("cfg moved", 1'h1, cfgError)
    `CHK("out moved", 2'h0, safeOut)
    `CHK("dyn kept", 1'h0, dynEnable)
    $display("test selchange done");
  endtask : t_selchange

  task automatic t_sync;
    syncEnable <= 1'b1;
    power_up(4'h5, 1'b0, 1'b0, 1'b1);
    drive(1'b1, 1'b0, 1'b1);
    repeat (60) @(negedge clk);
    drive(1'b1, 1'b1, 1'b1);
    repeat (10) @(negedge clk);
    `CHK("sync late", 1'h1, syncFault)
    `CHK("out late", 2'h0, safeOut)
    drive(1'b0, 1'b0, 1'b1);
    repeat (30) @(negedge clk);
    `CHK("sync clear", 1'h0, syncFault)
    drive(1'b1, 1'b1, 1'b1);
    wait_out(2'h3, 40);
    `CHK("out in time", 2'h3, safeOut)
    syncEnable <= 1'b0;
    $display("test sync done");
  endtask : t_sync

  // ============================================================
  // run control
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 8000)
    begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  initial
  begin
    arst_n = 1'b0;
    reqA = 1'b0;
    reqB = 1'b0;
    reqStart = 1'b0;
    syncEnable = 1'b0;
    selPos = 4'h5;
    t_manual();
    t_monitored();
    t_startup();
    t_decode();
    t_selchange();
    t_sync();
    tally_and_finish();
  end
endmodule : sss_sequencer_tb_top

// ---- sss_window_timer.sv ----
`timescale 1ns/1ps

module sss_window_timer #(
  parameter int COUNT = 20000000
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic run,
  output logic expired
);

  localparam int W = $clog2(COUNT + 1);
  localparam logic [W-1:0] LAST = W'(COUNT - 1);

  if (COUNT < 1)
  begin : g_bad_count
    $error("sss_window_timer: COUNT must be at least 1");
  end

  logic [W-1:0] cnt;
  wire atLast = (cnt == LAST);

  // ============================================================
  // counts while run holds, restarts when it drops
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      cnt <= '0;
    else if (!run)
      cnt <= '0;
    else if (!atLast)
      cnt <= cnt + W'(1);
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      expired <= 1'b0;
    else
      expired <= run && atLast;
  end

  chk_expiry_needs_run: assert property (
    @(posedge clk) disable iff (!arst_n)
    expired |-> $past(run))
    else $error("window expired without a running window");

endmodule : sss_window_timer
